// ### uart_line_status_flags.sv
// Line status flags of an asynchronous serial port, APB register slave
// Assumes receive and transmit datapaths give one-cycle event pulses on pclk
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "uart_lsr_defs.svh"

module uart_line_status_flags (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Receive datapath
  input  wire logic                  rx_char_done,
  input  wire logic                  rx_parity_bad,
  input  wire logic                  rx_stop_low,
  input  wire logic                  rx_break,
  input  wire logic                  rx_buffer_read,
  input  wire logic                  serial_receive_pin,
  output logic                       rx_resync,
  output logic                       rx_hold_idle,
  output logic                       fifo_enable,
  // Transmit datapath
  input  wire logic                  tx_holding_written,
  input  wire logic                  tx_holding_drained,
  input  wire logic                  tx_shift_empty,
  // Interrupt
  output logic                       irq
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  uart_lsr_pkg::apb_phase_e  phase_r;
  logic [31:0]               prdata_r;
  logic                      pready_r;
  logic                      pslverr_r;
  logic [7:0]                lsr_cap_r;
  logic                      cap_is_lsr_r;
  logic [7:0]                fcr_r;
  logic [7:0]                int_status_r;
  logic [7:0]                int_mask_r;
  logic                      irq_r;
  logic                      overrun_r;
  logic                      parity_r;
  logic                      framing_r;
  logic                      break_r;
  logic                      thr_empty_r;
  logic                      thr_empty_nxt;
  logic                      tx_empty_r;
  logic                      rx_err_r;
  logic                      resync_r;
  logic                      hold_idle_r;
  uart_lsr_pkg::rx_tag_t     char_tag;
  uart_lsr_pkg::rx_tag_t     head_tag;
  logic [`RX_CNT_W-1:0]      held_count;
  logic [`RX_CNT_W-1:0]      err_count;
  logic                      rx_full;
  logic                      rx_empty;
  logic                      head_new;
  logic [7:0]                lsr_value;
  logic [7:0]                lsr_clear;
  logic [7:0]                int_event;
  logic                      access_done;
  logic                      wr_done;
  logic                      lsr_read_done;
  logic                      overrun_set;

  ////////////////////////////////////////////////////////////////////////////
  // Error tag shadow of the receive FIFO
  assign char_tag = {rx_break, rx_stop_low, rx_parity_bad};

  rx_error_tags u_tags (
    .pclk        (pclk),
    .presetn     (presetn),
    .fifo_enable (fcr_r[`FCR_ENABLE_BIT]),
    .push        (rx_char_done),
    .push_tag    (char_tag),
    .pop         (rx_buffer_read),
    .head_tag    (head_tag),
    .held_count  (held_count),
    .err_count   (err_count),
    .full        (rx_full),
    .empty       (rx_empty),
    .head_new    (head_new)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode helpers
  assign access_done   = psel & penable & pready_r;
  assign wr_done       = access_done & pwrite;
  assign lsr_read_done = access_done & ~pwrite & cap_is_lsr_r;
  // Only flags that software actually saw are cleared
  assign lsr_clear     = lsr_read_done ? lsr_cap_r : 8'h00;
  assign overrun_set   = rx_char_done & rx_full;

  // Status value as software sees it
  always_comb begin
    lsr_value = 8'h00;
    lsr_value[`LSR_READY_BIT]     = ~rx_empty;
    lsr_value[`LSR_OVERRUN_BIT]   = overrun_r;
    lsr_value[`LSR_PARITY_BIT]    = parity_r;
    lsr_value[`LSR_FRAMING_BIT]   = framing_r;
    lsr_value[`LSR_BREAK_BIT]     = break_r;
    lsr_value[`LSR_THR_EMPTY_BIT] = thr_empty_r;
    lsr_value[`LSR_TX_EMPTY_BIT]  = tx_empty_r;
    lsr_value[`LSR_RX_ERR_BIT]    = rx_err_r & fcr_r[`FCR_ENABLE_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive error flags: set wins over a read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_r <= 1'b0;
    end else begin
      overrun_r <= overrun_set
                 | (overrun_r & ~lsr_clear[`LSR_OVERRUN_BIT]);
    end
  end

  // Head-of-FIFO flags rise as their character reaches the read position
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parity_r  <= 1'b0;
      framing_r <= 1'b0;
      break_r   <= 1'b0;
    end else begin
      parity_r  <= (head_new & head_tag[`TAG_PARITY_BIT])
                 | (parity_r & ~lsr_clear[`LSR_PARITY_BIT]);
      framing_r <= (head_new & head_tag[`TAG_FRAMING_BIT])
                 | (framing_r & ~lsr_clear[`LSR_FRAMING_BIT]);
      break_r   <= (head_new & head_tag[`TAG_BREAK_BIT])
                 | (break_r & ~lsr_clear[`LSR_BREAK_BIT]);
    end
  end

  // Error summary: set on load, cleared by a read when none remain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_err_r <= 1'b0;
    end else begin
      rx_err_r <= (rx_char_done & ~rx_full & (|char_tag))
                | (rx_err_r & ~(lsr_clear[`LSR_RX_ERR_BIT]
                                & (err_count == '0)));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit emptiness flags
  always_comb begin
    thr_empty_nxt = thr_empty_r;
    if (tx_holding_drained) begin
      thr_empty_nxt = 1'b1;
    end
    if (tx_holding_written) begin
      thr_empty_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_empty_r <= `THR_EMPTY_RST;
      tx_empty_r  <= `TX_EMPTY_RST;
    end else begin
      thr_empty_r <= thr_empty_nxt;
      tx_empty_r  <= thr_empty_nxt & tx_shift_empty;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver steering after framing errors and breaks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resync_r    <= 1'b0;
      hold_idle_r <= 1'b0;
    end else begin
      // Bad stop bit is treated as the next start bit
      resync_r    <= rx_char_done & rx_stop_low & ~rx_break;
      // Receiver parked until the line marks again
      hold_idle_r <= (rx_char_done & rx_break)
                   | (hold_idle_r & ~serial_receive_pin);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt events, same layout as the line status register
  always_comb begin
    int_event = 8'h00;
    int_event[`LSR_READY_BIT]     = rx_char_done & ~rx_full;
    int_event[`LSR_OVERRUN_BIT]   = overrun_set;
    int_event[`LSR_PARITY_BIT]    = head_new & head_tag[`TAG_PARITY_BIT];
    int_event[`LSR_FRAMING_BIT]   = head_new & head_tag[`TAG_FRAMING_BIT];
    int_event[`LSR_BREAK_BIT]     = head_new & head_tag[`TAG_BREAK_BIT];
    int_event[`LSR_THR_EMPTY_BIT] = thr_empty_nxt & ~thr_empty_r;
    int_event[`LSR_TX_EMPTY_BIT]  = thr_empty_nxt & tx_shift_empty
                                    & ~tx_empty_r;
    int_event[`LSR_RX_ERR_BIT]    = rx_char_done & ~rx_full & (|char_tag)
                                    & fcr_r[`FCR_ENABLE_BIT];
  end

  // Sticky status, write one to clear, event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status_r <= 8'h00;
    end else if (wr_done && paddr == `INT_STATUS_ADDR) begin
      int_status_r <= int_event | (int_status_r & ~pwdata[7:0]);
    end else begin
      int_status_r <= int_event | int_status_r;
    end
  end

  // Level interrupt from unmasked status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(int_status_r & int_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fcr_r      <= `FCR_RST;
      int_mask_r <= `INT_MASK_RST;
    end else if (wr_done) begin
      if (paddr == `FIFO_CTRL_ADDR) begin
        fcr_r <= pwdata[7:0];
      end
      if (paddr == `INT_MASK_ADDR) begin
        int_mask_r <= pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: read data captured in setup, ready in first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r      <= uart_lsr_pkg::APB_IDLE;
      pready_r     <= 1'b0;
      pslverr_r    <= 1'b0;
      prdata_r     <= 32'h0000_0000;
      lsr_cap_r    <= 8'h00;
      cap_is_lsr_r <= 1'b0;
    end else begin
      case (phase_r)
        uart_lsr_pkg::APB_IDLE: begin
          if (psel && !penable) begin
            phase_r      <= uart_lsr_pkg::APB_ANSWER;
            pready_r     <= 1'b1;
            pslverr_r    <= 1'b0;
            prdata_r     <= 32'h0000_0000;
            lsr_cap_r    <= 8'h00;
            cap_is_lsr_r <= 1'b0;
            case (paddr)
              `LINE_STATUS_ADDR: begin
                prdata_r     <= pwrite ? 32'h0000_0000
                                       : {24'h00_0000, lsr_value};
                lsr_cap_r    <= lsr_value;
                cap_is_lsr_r <= ~pwrite;
                pslverr_r    <= pwrite;
              end
              `FIFO_CTRL_ADDR: begin
                prdata_r <= {24'h00_0000, fcr_r};
              end
              `INT_STATUS_ADDR: begin
                prdata_r <= {24'h00_0000, int_status_r};
              end
              `INT_MASK_ADDR: begin
                prdata_r <= {24'h00_0000, int_mask_r};
              end
              default: begin
                pslverr_r <= 1'b1;
              end
            endcase
          end
        end
        uart_lsr_pkg::APB_ANSWER: begin
          if (psel && penable) begin
            phase_r      <= uart_lsr_pkg::APB_IDLE;
            pready_r     <= 1'b0;
            pslverr_r    <= 1'b0;
            cap_is_lsr_r <= 1'b0;
          end
        end
        default: begin
          phase_r  <= uart_lsr_pkg::APB_IDLE;
          pready_r <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  assign prdata       = prdata_r;
  assign pready       = pready_r;
  assign pslverr      = pslverr_r;
  assign irq          = irq_r;
  assign rx_resync    = resync_r;
  assign rx_hold_idle = hold_idle_r;
  assign fifo_enable  = fcr_r[`FCR_ENABLE_BIT];
endmodule // uart_line_status_flags

`default_nettype wire

// ### uart_lsr_defs.svh
// Offsets, field positions, reset values and sizes of the line status block
// Assumes inclusion by bare name from the block's design files
`ifndef UART_LSR_DEFS_SVH
`define UART_LSR_DEFS_SVH

// Register byte addresses
`define LINE_STATUS_ADDR   32'hE000_C014
`define FIFO_CTRL_ADDR     32'hE000_C040
`define INT_STATUS_ADDR    32'hE000_C044
`define INT_MASK_ADDR      32'hE000_C048

// Line status register fields
`define LSR_READY_BIT      0
`define LSR_OVERRUN_BIT    1
`define LSR_PARITY_BIT     2
`define LSR_FRAMING_BIT    3
`define LSR_BREAK_BIT      4
`define LSR_THR_EMPTY_BIT  5
`define LSR_TX_EMPTY_BIT   6
`define LSR_RX_ERR_BIT     7

// Error tag fields carried with each character
`define TAG_PARITY_BIT     0
`define TAG_FRAMING_BIT    1
`define TAG_BREAK_BIT      2
`define TAG_WIDTH          3

// FIFO control field and receive buffer sizes
`define FCR_ENABLE_BIT     0
`define RX_DEPTH           16
`define RX_PTR_W           4
`define RX_CNT_W           5

// Reset values
`define THR_EMPTY_RST      1'b1
`define TX_EMPTY_RST       1'b1
`define FCR_RST            8'h00
`define INT_MASK_RST       8'h00

`endif

// ### uart_lsr_pkg.sv
// Types shared by the line status block
// Assumes the defs header is compiled with it
`include "uart_lsr_defs.svh"

package uart_lsr_pkg;
  typedef logic [`TAG_WIDTH-1:0] rx_tag_t;
  typedef enum logic {APB_IDLE, APB_ANSWER} apb_phase_e;
endpackage

// ### rx_error_tags.sv
// Error tag shadow of the receive FIFO: one tag per held character
// Assumes push and pop pulses mirror the real FIFO, one cycle each
`timescale 1ns/1ns
`default_nettype none
`include "uart_lsr_defs.svh"

module rx_error_tags (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  fifo_enable,
  input  wire logic                  push,
  input  wire uart_lsr_pkg::rx_tag_t push_tag,
  input  wire logic                  pop,
  output uart_lsr_pkg::rx_tag_t      head_tag,
  output logic [`RX_CNT_W-1:0]       held_count,
  output logic [`RX_CNT_W-1:0]       err_count,
  output logic                       full,
  output logic                       empty,
  output logic                       head_new
);
  uart_lsr_pkg::rx_tag_t   tags_r [`RX_DEPTH];
  logic [`RX_PTR_W-1:0]    wr_ptr_r;
  logic [`RX_PTR_W-1:0]    rd_ptr_r;
  logic [`RX_CNT_W-1:0]    count_r;
  logic [`RX_CNT_W-1:0]    errs_r;
  logic                    head_new_r;
  logic [`RX_CNT_W-1:0]    cap;
  logic                    push_ok;
  logic                    pop_ok;

  // Single holding slot while the FIFO is off
  assign cap      = fifo_enable ? `RX_CNT_W'(`RX_DEPTH) : `RX_CNT_W'(1);
  assign full     = (count_r >= cap);
  assign empty    = (count_r == '0);
  assign push_ok  = push & ~full;
  assign pop_ok   = pop & ~empty;
  assign head_tag = tags_r[rd_ptr_r];
  assign held_count = count_r;
  assign err_count  = errs_r;
  assign head_new   = head_new_r;

  ////////////////////////////////////////////////////////////////////////////
  // Tag storage
  always_ff @(posedge pclk) begin
    if (push_ok) begin
      tags_r[wr_ptr_r] <= push_tag;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push_ok) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop_ok) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      count_r <= count_r + {{(`RX_CNT_W-1){1'b0}}, push_ok}
                         - {{(`RX_CNT_W-1){1'b0}}, pop_ok};
    end
  end

  // Count of held characters carrying any error tag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      errs_r <= '0;
    end else begin
      errs_r <= errs_r + {{(`RX_CNT_W-1){1'b0}}, push_ok & (|push_tag)}
                       - {{(`RX_CNT_W-1){1'b0}}, pop_ok & (|head_tag)};
    end
  end

  // Pulse in the cycle a new character stands at the head
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      head_new_r <= 1'b0;
    end else begin
      head_new_r <= (push_ok & (empty | (pop_ok & (count_r == 1))))
                  | (pop_ok & (count_r > 1));
    end
  end
endmodule // rx_error_tags

`default_nettype wire

// ### uart_lsr_properties.sv
// Port checker for the line status block, bound onto its top module
// Assumes the defs header and a single pclk domain with presetn
`timescale 1ns/1ns
`default_nettype none
`include "uart_lsr_defs.svh"

module uart_lsr_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_char_done,
  input wire logic        rx_stop_low,
  input wire logic        rx_break,
  input wire logic        serial_receive_pin,
  input wire logic        rx_resync,
  input wire logic        rx_hold_idle,
  input wire logic        fifo_enable
);
  logic en_bit;
  logic setup;

  // Helper terms: written FIFO enable bit and the setup phase
  assign en_bit = pwdata[`FCR_ENABLE_BIT];
  assign setup  = psel && !penable;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////
  a_zero_wait: assert property (setup |=> pready)
    else $error("no answer after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("answer held too long");
  a_err_with_ready: assert property (pslverr |->
    pready && prdata == '0)
    else $error("error response malformed");
  a_ro_write: assert property (setup && pwrite &&
    paddr == `LINE_STATUS_ADDR |=> pslverr)
    else $error("status write not refused");
  a_fifo_en_write: assert property (setup ##1 pready && pwrite &&
    paddr == `FIFO_CTRL_ADDR |=> fifo_enable == $past(en_bit))
    else $error("fifo enable not written");
  a_summary_off: assert property (setup && !pwrite && !fifo_enable &&
    paddr == `LINE_STATUS_ADDR |=> !prdata[`LSR_RX_ERR_BIT])
    else $error("summary set with fifo off");
  a_resync_pulse: assert property (rx_char_done && rx_stop_low &&
    !rx_break |=> rx_resync)
    else $error("no resync after bad stop");
  a_break_idle: assert property (rx_char_done && rx_break
    |=> rx_hold_idle)
    else $error("no idle after break");
  a_idle_release: assert property (rx_hold_idle && serial_receive_pin &&
    !rx_char_done |=> !rx_hold_idle)
    else $error("idle kept on marking line");
  a_idle_hold: assert property (rx_hold_idle && !serial_receive_pin
    |=> rx_hold_idle)
    else $error("idle dropped on spacing line");

  // Main scenarios
  c_resync: cover property (rx_resync);
  c_break: cover property (rx_hold_idle ##1 !rx_hold_idle);
  c_refused: cover property (pready && pslverr);
endmodule // uart_lsr_checker

bind uart_line_status_flags uart_lsr_checker i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rx_char_done(rx_char_done),
  .rx_stop_low(rx_stop_low), .rx_break(rx_break),
  .serial_receive_pin(serial_receive_pin), .rx_resync(rx_resync),
  .rx_hold_idle(rx_hold_idle), .fifo_enable(fifo_enable)
);
`default_nettype wire

// ### serial_far_end.sv
// Remote serial party: delivers tagged characters, drains transmit data
// Assumes send pulses spaced wider than a break's low stretch
`timescale 1ns/1ns
`default_nettype none
`include "uart_lsr_defs.svh"

module serial_far_end #(
  parameter int HOLD_WAIT = 6,
  parameter int SHIFT_LEN = 30,
  parameter int BREAK_LEN = 6
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  send,
  input  wire uart_lsr_pkg::rx_tag_t send_tag,
  input  wire logic                  tx_holding_written,
  output logic                       rx_char_done,
  output logic                       rx_parity_bad,
  output logic                       rx_stop_low,
  output logic                       rx_break,
  output logic                       serial_receive_pin,
  output logic                       tx_holding_drained,
  output logic                       tx_shift_empty
);
  int unsigned low_cnt;
  int unsigned hold_cnt;
  int unsigned shift_cnt;
  logic        hold_full;
  logic [2:0]  junk_r;

  ////////////////////////////////////////
  // Character strobe; tags scramble outside it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_char_done <= 1'b0;
      {rx_break, rx_stop_low, rx_parity_bad} <= 3'h0;
      junk_r <= 3'h0;
    end else begin
      junk_r <= junk_r + 3'h3;
      rx_char_done <= send;
      {rx_break, rx_stop_low, rx_parity_bad} <= send ? send_tag : ~junk_r;
    end
  end

  // Spacing line through a break, then marking again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt <= 0;
    end else if (send && send_tag[`TAG_BREAK_BIT]) begin
      low_cnt <= BREAK_LEN;
    end else if (low_cnt != 0) begin
      low_cnt <= low_cnt - 1;
    end
  end
  assign serial_receive_pin = (low_cnt == 0);

  // Holding waits, moves to shift, shift runs out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_full <= 1'b0;
      hold_cnt <= 0;
      shift_cnt <= 0;
      tx_holding_drained <= 1'b0;
    end else begin
      tx_holding_drained <= 1'b0;
      if (shift_cnt != 0) shift_cnt <= shift_cnt - 1;
      if (tx_holding_written) begin
        hold_full <= 1'b1;
        hold_cnt <= HOLD_WAIT;
      end else if (hold_full && hold_cnt != 0) begin
        hold_cnt <= hold_cnt - 1;
      end else if (hold_full && shift_cnt == 0) begin
        hold_full <= 1'b0;
        tx_holding_drained <= 1'b1;
        shift_cnt <= SHIFT_LEN;
      end
    end
  end
  assign tx_shift_empty = (shift_cnt == 0);
endmodule // serial_far_end
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the line status block
// Assumes the checker binds itself; far end models the serial party
`timescale 1ns/1ns
`default_nettype none
`include "uart_lsr_defs.svh"

module tb_top;
  logic                  pclk, presetn, psel, penable, pwrite, pready;
  logic [31:0]           paddr, pwdata, prdata, rdata;
  logic                  pslverr, rerr, irq, rx_char_done, rx_parity_bad;
  logic                  rx_stop_low, rx_break, rx_buffer_read, rx_resync;
  logic                  serial_receive_pin, rx_hold_idle, fifo_enable;
  logic                  tx_holding_written, tx_holding_drained;
  logic                  tx_shift_empty, send, e;
  uart_lsr_pkg::rx_tag_t send_tag, tg;
  uart_lsr_pkg::rx_tag_t q[$];
  int                    failures, compares, k;

  uart_line_status_flags i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_char_done(rx_char_done),
    .rx_parity_bad(rx_parity_bad), .rx_stop_low(rx_stop_low),
    .rx_break(rx_break), .rx_buffer_read(rx_buffer_read),
    .serial_receive_pin(serial_receive_pin), .rx_resync(rx_resync),
    .rx_hold_idle(rx_hold_idle), .fifo_enable(fifo_enable),
    .tx_holding_written(tx_holding_written),
    .tx_holding_drained(tx_holding_drained),
    .tx_shift_empty(tx_shift_empty), .irq(irq));

  serial_far_end i_far (
    .pclk(pclk), .presetn(presetn), .send(send), .send_tag(send_tag),
    .tx_holding_written(tx_holding_written), .rx_char_done(rx_char_done),
    .rx_parity_bad(rx_parity_bad), .rx_stop_low(rx_stop_low),
    .rx_break(rx_break), .serial_receive_pin(serial_receive_pin),
    .tx_holding_drained(tx_holding_drained),
    .tx_shift_empty(tx_shift_empty));

  ////////////////////////////////////////
  // Clock and helpers
  always #10 pclk = ~pclk;

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Request held until pready is seen high at a rising edge
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      $display("[ERR] %0t no bus answer", $time);
    end
    rdata = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic send_char(input uart_lsr_pkg::rx_tag_t t);
    @(posedge pclk);
    send <= 1'b1;
    send_tag <= t;
    @(posedge pclk);
    send <= 1'b0;
    cyc(8);
  endtask

  task automatic pop_char();
    @(posedge pclk);
    rx_buffer_read <= 1'b1;
    @(posedge pclk);
    rx_buffer_read <= 1'b0;
    cyc(4);
  endtask

  // Expected status word from its fields
  function automatic logic [31:0] lsr(input logic [1:0] tx, input logic rxe,
      input uart_lsr_pkg::rx_tag_t t, input logic [1:0] lo);
    return {24'h0, rxe, tx, t, lo};
  endfunction

  function automatic logic anyerr();
    foreach (q[i]) if (q[i] != 3'h0) return 1'b1;
    return 1'b0;
  endfunction

  task automatic results();
    if (failures == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////
  // Watchdog
  initial begin
    #200_000;
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end

  // Main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, rx_buffer_read, tx_holding_written, send} = '0;
    {paddr, pwdata} = '0;
    send_tag = 3'h0;
    failures = 0;
    compares = 0;
    void'($urandom(32'hf3db_8e16));
    cyc(8);
    presetn <= 1'b1;
    apb(1'b0, `LINE_STATUS_ADDR, '0);
    chk(rdata, lsr(2'b11, 1'b0, 3'h0, 2'b00));
    chk({31'h0, fifo_enable}, 32'h0);
    apb(1'b1, `LINE_STATUS_ADDR, 32'h0000_00ff);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b0, 32'hE000_C0F0, '0);
    chk({rdata[30:0], rerr}, 32'h1);
    // FIFO off: one place, second character overruns
    send_char(3'h1);
    send_char(3'h0);
    apb(1'b0, `LINE_STATUS_ADDR, '0);
    chk(rdata, lsr(2'b11, 1'b0, 3'h1, 2'b11));
    apb(1'b0, `LINE_STATUS_ADDR, '0);
    chk(rdata, lsr(2'b11, 1'b0, 3'h0, 2'b01));
    // Interrupt raised, cleared, then masked
    apb(1'b1, `INT_MASK_ADDR, 32'h0000_0001);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `INT_STATUS_ADDR, 32'h0000_0001);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, `INT_STATUS_ADDR, '0);
    chk({31'h0, rdata[0]}, 32'h0);
    apb(1'b1, `INT_MASK_ADDR, 32'h0000_0000);
    pop_char();
    apb(1'b0, `LINE_STATUS_ADDR, '0);
    chk(rdata, lsr(2'b11, 1'b0, 3'h0, 2'b00));
    // FIFO on: random tag bursts, first burst clean then framing
    apb(1'b1, `FIFO_CTRL_ADDR, 32'h0000_0001);
    for (int r = 0; r < 12; r++) begin
      k = (r == 0) ? 2 : $urandom_range(4, 1);
      for (int i = 0; i < k; i++) begin
        tg = (r == 0) ? 3'(2 * i) : 3'($urandom_range(7, 0));
        q.push_back(tg);
        send_char(tg);
      end
      e = anyerr();
      while (q.size() > 0) begin
        apb(1'b0, `LINE_STATUS_ADDR, '0);
        chk(rdata, lsr(2'b11, e, q[0], 2'b01));
        e = anyerr();
        pop_char();
        void'(q.pop_front());
      end
      apb(1'b0, `LINE_STATUS_ADDR, '0);
      chk(rdata, lsr(2'b11, e, 3'h0, 2'b00));
      apb(1'b0, `LINE_STATUS_ADDR, '0);
      chk(rdata, lsr(2'b11, 1'b0, 3'h0, 2'b00));
    end
    chk({31'h0, irq}, 32'h0);
    // Transmit: holding written, drained, shift runs out
    @(posedge pclk);
    tx_holding_written <= 1'b1;
    @(posedge pclk);
    tx_holding_written <= 1'b0;
    apb(1'b0, `LINE_STATUS_ADDR, '0);
    chk(rdata, lsr(2'b00, 1'b0, 3'h0, 2'b00));
    cyc(12);
    apb(1'b0, `LINE_STATUS_ADDR, '0);
    chk(rdata, lsr(2'b01, 1'b0, 3'h0, 2'b00));
    cyc(40);
    apb(1'b0, `LINE_STATUS_ADDR, '0);
    chk(rdata, lsr(2'b11, 1'b0, 3'h0, 2'b00));
    results();
  end
endmodule // tb_top
`default_nettype wire
